// ---- bench/lvc_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module lvc_host_model (
    // clock
    input wire logic core_clk,
    // parallel register port
    output logic cpuCs,
    output logic cpuWr,
    output logic cpuRd,
    output logic [7:0] cpuAddr,
    output logic [7:0] cpuWdata
);
    initial begin
        cpuCs = 1'b0;
        cpuWr = 1'b0;
        cpuRd = 1'b0;
        cpuAddr = 8'h00;
        cpuWdata = 8'h00;
    end
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge core_clk);
        cpuCs = 1'b1;
        cpuWr = w;
        cpuRd = ~w;
        cpuAddr = a;
        cpuWdata = d;
        @(negedge core_clk);
        cpuCs = 1'b0;
        cpuWr = 1'b0;
        cpuRd = 1'b0;
        // released lines show the inverse so a stale value cannot pass
        cpuAddr = ~a;
        cpuWdata = ~d;
    endtask : acc
    // a clear bit stays set for the full hold time before it is dropped
    task automatic clr(input logic [7:0] d);
        acc(lvc_pkg::CNT_CTRL_ADDR, d, 1'b1);
        repeat (lvc_pkg::CLR_HOLD_CYCLES) @(negedge core_clk);
        acc(lvc_pkg::CNT_CTRL_ADDR, 8'h00, 1'b1);
    endtask : clr
endmodule : lvc_host_model
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cpuCs, cpuWr, cpuRd;
    logic [7:0] cpuAddr, cpuWdata, cpuRdata_reg;
    logic floatTestPin_n = 1'b1;
    logic hostModePin = 1'b1;
    logic txOnPin = 1'b0;
    logic rxTermPin = 1'b0;
    logic hostTxOnBit = 1'b0;
    logic hostRxTermBit = 1'b0;
    logic [7:0] chanTxOnBits = 8'h00;
    logic [7:0] chanRxTermBits = 8'h00;
    logic e1Mode = 1'b1;
    logic [7:0] rxBitValid = 8'h00;
    logic [7:0] rxZero = 8'h00;
    logic [7:0] lcvPulse = 8'h00;
    logic outputsFloat_reg;
    logic [7:0] transmitter_enable_reg, rxTermSel_reg, rxLos_reg;
    logic [7:0] q[$];
    logic rdPend = 1'b0;
    logic [15:0] g;
    logic [15:0] cnt[8];
    logic [15:0] hld[8];
    logic [7:0] ad[4] = '{8'h81, 8'h82, 8'h8c, 8'h8d};
    logic [7:0] mk[4] = '{8'h03, 8'hc0, 8'h0f, 8'h1f};
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;

    always #5 core_clk = ~core_clk;

    lvc_host_model i_lvc_host_model (.core_clk(core_clk), .cpuCs(cpuCs), .cpuWr(cpuWr),
        .cpuRd(cpuRd), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata));

    lvc_global_ctrl i_lvc_global_ctrl (.core_clk(core_clk), .sys_rst(sys_rst), .cpuCs(cpuCs),
        .cpuWr(cpuWr), .cpuRd(cpuRd), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata),
        .cpuRdata_reg(cpuRdata_reg), .floatTestPin_n(floatTestPin_n),
        .hostModePin(hostModePin), .txOnPin(txOnPin), .rxTermPin(rxTermPin),
        .hostTxOnBit(hostTxOnBit), .hostRxTermBit(hostRxTermBit),
        .chanTxOnBits(chanTxOnBits), .chanRxTermBits(chanRxTermBits), .e1Mode(e1Mode),
        .rxBitValid(rxBitValid), .rxZero(rxZero), .lcvPulse(lcvPulse),
        .outputsFloat_reg(outputsFloat_reg), .transmitter_enable_reg(transmitter_enable_reg),
        .rxTermSel_reg(rxTermSel_reg), .rxLos_reg(rxLos_reg));

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic end_sim;
        // an expected read that never came back counts as a mismatch
        if (q.size() != 0) n_mismatch++;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_lvc_host_model.acc(a, d, 1'b1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        q.push_back(exp);
        i_lvc_host_model.acc(a, 8'h00, 1'b0);
    endtask : rd

    task automatic readCh(input int ch);
        wr(lvc_pkg::CHAN_SEL_ADDR, 8'(ch + 1));
        wr(lvc_pkg::CNT_CTRL_ADDR, 8'h00);
        rd(lvc_pkg::READBACK_ADDR, hld[ch][7:0]);
        wr(lvc_pkg::CNT_CTRL_ADDR, 8'h04);
        rd(lvc_pkg::READBACK_ADDR, hld[ch][15:8]);
        wr(lvc_pkg::CNT_CTRL_ADDR, 8'h00);
    endtask : readCh

    task automatic latchAll;
        wr(lvc_pkg::CNT_CTRL_ADDR, 8'h08);
        wr(lvc_pkg::CNT_CTRL_ADDR, 8'h00);
        hld = cnt;
    endtask : latchAll

    task automatic pulses(input int n);
        repeat (n) begin
            @(negedge core_clk);
            lcvPulse = 8'($urandom);
            for (int c = 0; c < 8; c++) cnt[c] += 16'(lcvPulse[c]);
        end
        @(negedge core_clk);
        lcvPulse = 8'h00;
    endtask : pulses

    // zero bits raise rxZero on channel 0 only, so other channels must stay clear
    task automatic bits(input int n, input logic z, input logic [7:0] los);
        repeat (n) begin
            @(negedge core_clk);
            rxBitValid = 8'h01;
            rxZero = {7'h00, z};
        end
        @(negedge core_clk);
        rxBitValid = 8'h00;
        check("signal loss", rxLos_reg, los);
    endtask : bits

    always @(posedge core_clk) rdPend <= cpuCs & cpuRd;
    always @(negedge core_clk) begin
        if (rdPend === 1'b1 && q.size() > 0) check("read data", cpuRdata_reg, q.pop_front());
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        for (int c = 0; c < 8; c++) cnt[c] = 16'h0000;
        void'($urandom(6));
        repeat (10) @(negedge core_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 4; i++) rd(ad[i], 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(ad[i], 8'hff);
            rd(ad[i], mk[i]);
            wr(ad[i], 8'h00);
        end
        wr(lvc_pkg::READBACK_ADDR, 8'hff);
        rd(lvc_pkg::READBACK_ADDR, 8'h00);
        rd(8'h90, 8'h00);
        for (int i = 0; i < 10; i++) begin
            g = 16'($urandom);
            {floatTestPin_n, hostModePin, txOnPin, rxTermPin, hostTxOnBit, hostRxTermBit} = g[5:0];
            chanTxOnBits = 8'($urandom);
            chanRxTermBits = 8'($urandom);
            wr(lvc_pkg::SOURCE_ADDR, {g[7:6], 6'h00});
            wr(lvc_pkg::LOS_TEST_ADDR, {7'h00, g[8]});
            repeat (4) @(negedge core_clk);
            check("float", {7'h00, outputsFloat_reg}, {7'h00, g[8] | ~g[5]});
            check("tx on", transmitter_enable_reg, g[7] ? chanTxOnBits : {8{g[4] ? g[1] : g[3]}});
            check("term", rxTermSel_reg,
                g[6] ? {8{g[2]}} : {8{g[4] ? g[0] : g[2]}} | chanRxTermBits);
        end
        floatTestPin_n = 1'b1;
        wr(lvc_pkg::LOS_TEST_ADDR, 8'h00);
        pulses(600);
        latchAll();
        for (int ch = 0; ch < 8; ch++) readCh(ch);
        wr(lvc_pkg::CHAN_SEL_ADDR, 8'h09);
        rd(lvc_pkg::READBACK_ADDR, 8'h00);
        pulses(50);
        wr(lvc_pkg::CHAN_SEL_ADDR, 8'h06);
        wr(lvc_pkg::CNT_CTRL_ADDR, 8'h02);
        wr(lvc_pkg::CNT_CTRL_ADDR, 8'h00);
        hld[5] = cnt[5];
        readCh(5);
        readCh(4);
        wr(lvc_pkg::CHAN_SEL_ADDR, 8'h04);
        i_lvc_host_model.clr(8'h01);
        cnt[3] = 16'h0000;
        latchAll();
        readCh(3);
        readCh(2);
        i_lvc_host_model.clr(8'h10);
        for (int c = 0; c < 8; c++) cnt[c] = 16'h0000;
        latchAll();
        readCh(0);
        readCh(7);
        bits(31, 1'b1, 8'h00);
        bits(1, 1'b1, 8'h01);
        bits(1, 1'b0, 8'h00);
        e1Mode = 1'b0;
        bits(174, 1'b1, 8'h00);
        bits(1, 1'b1, 8'h01);
        bits(1, 1'b0, 8'h00);
        e1Mode = 1'b1;
        wr(lvc_pkg::LOS_TEST_ADDR, 8'h02);
        bits(4095, 1'b1, 8'h00);
        bits(1, 1'b1, 8'h01);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire

// ---- logic/lvc_chan_counter.sv ----
`timescale 1ns/100ps
`default_nettype none
module lvc_chan_counter (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // receive path of this channel
    input wire logic rxBitValid,
    input wire logic rxZero,
    input wire logic lcvPulse,
    input wire logic e1Mode,
    // control
    input wire logic extLos,
    input wire logic clear,
    input wire logic latch,
    // state
    output logic [lvc_pkg::CNT_W-1:0] count_reg,
    output logic [lvc_pkg::CNT_W-1:0] hold_reg,
    output logic rxLos_reg
);
    logic [lvc_pkg::RUN_W-1:0] run_reg;
    logic [lvc_pkg::RUN_W-1:0] limit;

    always_comb begin
        if (extLos) begin
            limit = lvc_pkg::EXT_LOS_ZEROS;
        end else if (e1Mode) begin
            limit = lvc_pkg::E1_LOS_ZEROS;
        end else begin
            limit = lvc_pkg::T1_LOS_ZEROS;
        end
    end

    // saturate the run so a long idle line cannot wrap back below the limit
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            run_reg <= '0;
        end else if (rxBitValid) begin
            if (!rxZero) begin
                run_reg <= '0;
            end else if (run_reg < limit) begin
                run_reg <= run_reg + 13'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxLos_reg <= 1'b0;
        end else if (rxBitValid) begin
            rxLos_reg <= rxZero && (run_reg + 13'h0001 >= limit);
        end
    end

    // clear wins over a violation arriving in the same cycle; counter sticks at full scale
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= lvc_pkg::CNT_RESET;
        end else if (clear) begin
            count_reg <= lvc_pkg::CNT_RESET;
        end else if (lcvPulse && count_reg != 16'hffff) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_reg <= lvc_pkg::CNT_RESET;
        end else if (latch) begin
            hold_reg <= count_reg;
        end
    end

    los_rise_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(rxLos_reg) |-> $past(rxZero) && ($past(run_reg) + 13'h0001 >= $past(limit)))
        else $error("signal loss declared before zero run reached threshold");
    count_inc_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        lcvPulse && !clear && count_reg != 16'hffff |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("violation counter did not advance");
endmodule : lvc_chan_counter
`default_nettype wire

// ---- logic/lvc_global_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module lvc_global_ctrl (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // parallel register port
    input wire logic cpuCs,
    input wire logic cpuWr,
    input wire logic cpuRd,
    input wire logic [7:0] cpuAddr,
    input wire logic [7:0] cpuWdata,
    output logic [7:0] cpuRdata_reg,
    // device pins
    input wire logic floatTestPin_n,
    input wire logic hostModePin,
    input wire logic txOnPin,
    input wire logic rxTermPin,
    // host global bits and per-channel bits from channel registers
    input wire logic hostTxOnBit,
    input wire logic hostRxTermBit,
    input wire logic [7:0] chanTxOnBits,
    input wire logic [7:0] chanRxTermBits,
    // receive paths
    input wire logic e1Mode,
    input wire logic [7:0] rxBitValid,
    input wire logic [7:0] rxZero,
    input wire logic [7:0] lcvPulse,
    // results
    output logic outputsFloat_reg,
    output logic [7:0] transmitter_enable_reg,
    output logic [7:0] rxTermSel_reg,
    output logic [7:0] rxLos_reg
);
    lvc_pkg::lvc_ctrl_t ctrl_reg;
    logic [3:0] pinMeta_reg;
    logic [3:0] pinSync_reg;
    logic wrEn;
    logic rdEn;
    logic selValid;
    logic [2:0] selIdx;
    logic [7:0][15:0] countAll;
    logic [7:0][15:0] holdAll;
    logic [15:0] selHold;
    logic [7:0] readByte;
    logic globalTx;
    logic globalTerm;

    assign wrEn = cpuCs && cpuWr;
    assign rdEn = cpuCs && cpuRd;

    // pins are asynchronous to core_clk
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinMeta_reg <= 4'h1;
            pinSync_reg <= 4'h1;
        end else begin
            pinMeta_reg <= {rxTermPin, txOnPin, hostModePin, floatTestPin_n};
            pinSync_reg <= pinMeta_reg;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= lvc_pkg::CTRL_RESET;
        end else if (wrEn) begin
            unique case (cpuAddr)
                lvc_pkg::LOS_TEST_ADDR: begin
                    ctrl_reg.extLos <= cpuWdata[lvc_pkg::EXT_LOS_BIT];
                    ctrl_reg.floatTest <= cpuWdata[lvc_pkg::FLOAT_TEST_BIT];
                end
                lvc_pkg::SOURCE_ADDR: begin
                    ctrl_reg.txSrc <= cpuWdata[lvc_pkg::TX_SRC_BIT];
                    ctrl_reg.termSrc <= cpuWdata[lvc_pkg::TERM_SRC_BIT];
                end
                lvc_pkg::CHAN_SEL_ADDR: begin
                    ctrl_reg.chanSel <= cpuWdata[3:0];
                end
                lvc_pkg::CNT_CTRL_ADDR: begin
                    ctrl_reg.clrAll <= cpuWdata[lvc_pkg::CLR_ALL_BIT];
                    ctrl_reg.latchAll <= cpuWdata[lvc_pkg::LATCH_ALL_BIT];
                    ctrl_reg.byteChoice <= cpuWdata[lvc_pkg::BYTE_CHOICE_BIT];
                    ctrl_reg.latchSel <= cpuWdata[lvc_pkg::LATCH_SEL_BIT];
                    ctrl_reg.clrSel <= cpuWdata[lvc_pkg::CLR_SEL_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // codes above eight select nothing, just like code zero
    assign selValid = ctrl_reg.chanSel != lvc_pkg::SEL_NONE
        && ctrl_reg.chanSel <= lvc_pkg::SEL_LAST;
    assign selIdx = 3'(ctrl_reg.chanSel - 4'h1);

    genvar ch;
    generate
        for (ch = 0; ch < lvc_pkg::CHANNELS; ch++) begin : gChan
            logic chosen;
            assign chosen = selValid && selIdx == 3'(ch);
            lvc_chan_counter uCount (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .rxBitValid(rxBitValid[ch]),
                .rxZero(rxZero[ch]),
                .lcvPulse(lcvPulse[ch]),
                .e1Mode(e1Mode),
                .extLos(ctrl_reg.extLos),
                .clear(ctrl_reg.clrAll || (ctrl_reg.clrSel && chosen)),
                .latch(ctrl_reg.latchAll || (ctrl_reg.latchSel && chosen)),
                .count_reg(countAll[ch]),
                .hold_reg(holdAll[ch]),
                .rxLos_reg(rxLos_reg[ch])
            );
        end
    endgenerate

    assign selHold = selValid ? holdAll[selIdx] : lvc_pkg::CNT_RESET;
    assign readByte = ctrl_reg.byteChoice ? selHold[15:8] : selHold[7:0];

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpuRdata_reg <= 8'h00;
        end else if (rdEn) begin
            unique case (cpuAddr)
                lvc_pkg::LOS_TEST_ADDR: begin
                    cpuRdata_reg <= {6'h00, ctrl_reg.extLos, ctrl_reg.floatTest};
                end
                lvc_pkg::SOURCE_ADDR: begin
                    cpuRdata_reg <= {ctrl_reg.txSrc, ctrl_reg.termSrc, 6'h00};
                end
                lvc_pkg::CHAN_SEL_ADDR: begin
                    cpuRdata_reg <= {4'h0, ctrl_reg.chanSel};
                end
                lvc_pkg::CNT_CTRL_ADDR: begin
                    cpuRdata_reg <= {3'h0, ctrl_reg.clrAll, ctrl_reg.latchAll,
                        ctrl_reg.byteChoice, ctrl_reg.latchSel, ctrl_reg.clrSel};
                end
                lvc_pkg::READBACK_ADDR: begin
                    cpuRdata_reg <= readByte;
                end
                default: begin
                    cpuRdata_reg <= 8'h00;
                end
            endcase
        end
    end

    // float request is either the register bit or the active-low pin
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            outputsFloat_reg <= 1'b0;
        end else begin
            outputsFloat_reg <= ctrl_reg.floatTest || !pinSync_reg[0];
        end
    end

    assign globalTx = pinSync_reg[1] ? hostTxOnBit : pinSync_reg[2];
    assign globalTerm = pinSync_reg[1] ? hostRxTermBit : pinSync_reg[3];

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            transmitter_enable_reg <= 8'h00;
        end else if (ctrl_reg.txSrc) begin
            transmitter_enable_reg <= chanTxOnBits;
        end else begin
            transmitter_enable_reg <= {8{globalTx}};
        end
    end

    // in shared mode a channel bit can add termination on top of the global choice
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxTermSel_reg <= 8'h00;
        end else if (ctrl_reg.termSrc) begin
            rxTermSel_reg <= {8{pinSync_reg[3]}};
        end else begin
            rxTermSel_reg <= {8{globalTerm}} | chanRxTermBits;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // write then read two cycles later must return the written field with reserved bits zero
    sel_write_a: assert property (
        (wrEn && cpuAddr == lvc_pkg::CHAN_SEL_ADDR) ##2
        (rdEn && cpuAddr == lvc_pkg::CHAN_SEL_ADDR) |=>
        cpuRdata_reg == ($past(cpuWdata, 3) & lvc_pkg::CHAN_SEL_MASK))
        else $error("select register readback does not match masked write");
    none_read_a: assert property (
        rdEn && cpuAddr == lvc_pkg::READBACK_ADDR && !selValid |=> cpuRdata_reg == 8'h00)
        else $error("readback nonzero with no channel selected");
    byte_read_a: assert property (
        rdEn && cpuAddr == lvc_pkg::READBACK_ADDR && selValid |=> cpuRdata_reg ==
        ($past(ctrl_reg.byteChoice) ? $past(holdAll[selIdx][15:8]) : $past(holdAll[selIdx][7:0])))
        else $error("readback byte does not match selected holding register");
    clear_all_a: assert property (
        ctrl_reg.clrAll |=> countAll == '0)
        else $error("clear-all left a counter nonzero");
    latch_all_a: assert property (
        ctrl_reg.latchAll |=> holdAll == $past(countAll))
        else $error("latch-all did not copy every counter");
    latch_sel_a: assert property (
        ctrl_reg.latchSel && selValid |=> holdAll[$past(selIdx)] == $past(countAll[selIdx]))
        else $error("selected counter not latched");
    clear_sel_a: assert property (
        ctrl_reg.clrSel && selValid |=> countAll[$past(selIdx)] == 16'h0000)
        else $error("selected counter not cleared");
    float_out_a: assert property (
        ctrl_reg.floatTest |=> outputsFloat_reg)
        else $error("float test bit did not float outputs");
    tx_source_a: assert property (
        ctrl_reg.txSrc |=> transmitter_enable_reg == $past(chanTxOnBits))
        else $error("transmitters not following channel enables");
    term_source_a: assert property (
        ctrl_reg.termSrc |=> rxTermSel_reg == {8{$past(pinSync_reg[3])}})
        else $error("termination not following pin");

    readback_c: cover property (rdEn && cpuAddr == lvc_pkg::READBACK_ADDR && selValid
        && ctrl_reg.byteChoice);
    clear_held_c: cover property (ctrl_reg.clrAll [*8]);
    los_c: cover property ($rose(rxLos_reg[0]) && ctrl_reg.extLos);
endmodule : lvc_global_ctrl
`default_nettype wire

// ---- logic/lvc_pkg.sv ----
package lvc_pkg;
    // register addresses on the parallel port
    localparam logic [7:0] LOS_TEST_ADDR = 8'h81;
    localparam logic [7:0] SOURCE_ADDR = 8'h82;
    localparam logic [7:0] CHAN_SEL_ADDR = 8'h8c;
    localparam logic [7:0] CNT_CTRL_ADDR = 8'h8d;
    localparam logic [7:0] READBACK_ADDR = 8'h8e;
    // writable bits per register; the rest are reserved and read zero
    localparam logic [7:0] LOS_TEST_MASK = 8'h03;
    localparam logic [7:0] SOURCE_MASK = 8'hc0;
    localparam logic [7:0] CHAN_SEL_MASK = 8'h0f;
    localparam logic [7:0] CNT_CTRL_MASK = 8'h1f;
    // field positions
    localparam int EXT_LOS_BIT = 1;
    localparam int FLOAT_TEST_BIT = 0;
    localparam int TX_SRC_BIT = 7;
    localparam int TERM_SRC_BIT = 6;
    localparam int CLR_ALL_BIT = 4;
    localparam int LATCH_ALL_BIT = 3;
    localparam int BYTE_CHOICE_BIT = 2;
    localparam int LATCH_SEL_BIT = 1;
    localparam int CLR_SEL_BIT = 0;
    // sizes
    localparam int CHANNELS = 8;
    localparam int CNT_W = 16;
    localparam int RUN_W = 13;
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_LAST = 4'h8;
    // zero-run thresholds for receive signal loss
    localparam logic [RUN_W-1:0] EXT_LOS_ZEROS = 13'h1000;
    localparam logic [RUN_W-1:0] T1_LOS_ZEROS = 13'h00af;
    localparam logic [RUN_W-1:0] E1_LOS_ZEROS = 13'h0020;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    // host holds a clear bit for at least this long
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLR_HOLD_NS = 1000;
    localparam int CLR_HOLD_CYCLES = (CLR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic extLos;
        logic floatTest;
        logic txSrc;
        logic termSrc;
        logic [3:0] chanSel;
        logic clrAll;
        logic latchAll;
        logic byteChoice;
        logic latchSel;
        logic clrSel;
    } lvc_ctrl_t;

    localparam lvc_ctrl_t CTRL_RESET = '0;
endpackage : lvc_pkg
